// ===== design/ccvw_calendar_clock_map.vh
`ifndef CCVW_CALENDAR_CLOCK_MAP_VH
`define CCVW_CALENDAR_CLOCK_MAP_VH

// register byte addresses on the control bus
`define CCVW_ADDR_CFG      8'h00
`define CCVW_ADDR_TIME     8'h04
`define CCVW_ADDR_ALARM    8'h08
`define CCVW_ADDR_ALCFG    8'h0c
`define CCVW_ADDR_KEY      8'h10
`define CCVW_ADDR_PINSEL   8'h14

// config_trim_register and alarm_config_register fields
`define CCVW_CFG_EN        15
`define CCVW_CFG_UNLOCK    13
`define CCVW_CFG_OE        10
`define CCVW_PTR_HI        9
`define CCVW_PTR_LO        8
`define CCVW_BYTE_HI       15:8
`define CCVW_BYTE_LO       7:0
`define CCVW_ALCFG_TOP     15:10

// window pointer codes
`define CCVW_PTR_MINUTES_SECONDS_PAIR    2'b00
`define CCVW_PTR_WDHR      2'b01
`define CCVW_PTR_MONDAY    2'b10
`define CCVW_PTR_YEAR      2'b11

// unlock key sequence and its window
`define CCVW_KEY_FIRST     8'h55
`define CCVW_KEY_SECOND    8'haa
`define CCVW_CLK_NS        20
`define CCVW_UNLOCK_WIN_NS 160
`define CCVW_UNLOCK_CYC    ((`CCVW_UNLOCK_WIN_NS) / (`CCVW_CLK_NS))

// oscillator timebase, 32768 ticks per second
`define CCVW_SEC_END       18'd32767
`define CCVW_HALF_START    18'd16384
`define CCVW_RIPPLE_TICKS  18'd32

// bus responses
`define CCVW_RESP_OK       2'b00
`define CCVW_RESP_SLVERR   2'b10

// calendar field limits and reset values (bcd)
`define CCVW_SEC_LAST      8'h59
`define CCVW_HR_LAST       8'h23
`define CCVW_WDAY_LAST     8'h06
`define CCVW_MON_LAST      8'h12
`define CCVW_YR_LAST       8'h99
`define CCVW_FIRST_ONE     8'h01
`define CCVW_ZERO          8'h00
`define CCVW_FEB           8'h02
`define CCVW_MASK_MINUTES_SECONDS_PAIR   8'h7f
`define CCVW_MASK_HR       8'h3f
`define CCVW_MASK_WDAY     8'h07
`define CCVW_MASK_MON      8'h1f

`endif

// ===== design/ccvw_calendar_clock.v
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ccvw_calendar_clock_map.vh"

module ccvw_calendar_clock (
  // clock and resets
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        porRst_n,
  // axi4-lite write channels
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // axi4-lite read channels
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // timebase and alarm source
  input  wire        xtalClk,
  input  wire        alarmPulse,
  // calendar output pin
  output reg         calPin,
  output reg         calPinOe
);

  // unlock window in bus clocks, cut on purpose to the counter width
  localparam integer UNLOCK_CYC_FULL = `CCVW_UNLOCK_CYC;
  localparam [7:0]   UNLOCK_CYC      = UNLOCK_CYC_FULL[7:0];

  // write channel holding state
  reg        awHeld;
  reg [7:0]  awAddrQ;
  reg        wHeld;
  reg [31:0] wDataQ;
  reg [3:0]  wStrbQ;
  // config_trim_register fields
  reg        calendarEnable;
  reg        valueWriteUnlock;
  reg        pinOutputEnable;
  reg [1:0]  valuePtr;
  reg [7:0]  driftTrim;
  // alarm_config_register fields and alarm values
  reg [5:0]  alarmCfgTop;
  reg [1:0]  alarmPtr;
  reg [7:0]  alarmRepeat;
  reg [7:0]  alarmMin;
  reg [7:0]  alarmSec;
  reg [7:0]  alarmWday;
  reg [7:0]  alarmHr;
  reg [7:0]  alarmMon;
  reg [7:0]  alarmDay;
  reg        secondsClockSel;
  // unlock key tracking
  reg        keyStage;
  reg [7:0]  armCnt;
  // timebase and calendar
  reg        oscPrev;
  reg [17:0] preCnt;
  reg [7:0]  sec;
  reg [7:0]  min;
  reg [7:0]  hr;
  reg [7:0]  wday;
  reg [7:0]  day;
  reg [7:0]  mon;
  reg [7:0]  yr;
  reg [31:0] rdMux;

  // bcd increment of a two-digit value
  function [7:0] bcdInc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcdInc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcdInc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // last day of month in bcd; year 00 counts as leap, right for 2000-2099
  function [7:0] lastDay;
    input [7:0] m;
    input [7:0] y;
    reg         leap;
    begin
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      if (m == `CCVW_FEB) begin
        lastDay = leap ? 8'h29 : 8'h28;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
        lastDay = 8'h30;
      end else begin
        lastDay = 8'h31;
      end
    end
  endfunction

  // pointer step-down by up to two accesses, saturating at 00
  function [1:0] ptrDec;
    input [1:0] p;
    input [1:0] n;
    begin
      ptrDec = (p > n) ? (p - n) : `CCVW_PTR_MINUTES_SECONDS_PAIR;
    end
  endfunction

  // address hits a mapped register
  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a == `CCVW_ADDR_CFG) || (a == `CCVW_ADDR_TIME) ||
                 (a == `CCVW_ADDR_ALARM) || (a == `CCVW_ADDR_ALCFG) ||
                 (a == `CCVW_ADDR_KEY) || (a == `CCVW_ADDR_PINSEL);
    end
  endfunction

  // bus handshakes; one write and one read in flight at most
  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;
  assign arready = !rvalid;

  wire wrDo = awHeld && wHeld && !bvalid;
  wire rdDo = arvalid && arready;

  wire wrCfg   = wrDo && (awAddrQ == `CCVW_ADDR_CFG);
  wire wrTime  = wrDo && (awAddrQ == `CCVW_ADDR_TIME);
  wire wrAlarm = wrDo && (awAddrQ == `CCVW_ADDR_ALARM);
  wire wrAlcfg = wrDo && (awAddrQ == `CCVW_ADDR_ALCFG);
  wire wrKey   = wrDo && (awAddrQ == `CCVW_ADDR_KEY) && wStrbQ[0];
  wire wrPin   = wrDo && (awAddrQ == `CCVW_ADDR_PINSEL) && wStrbQ[0];
  wire rdTime  = rdDo && (araddr == `CCVW_ADDR_TIME);
  wire rdAlarm = rdDo && (araddr == `CCVW_ADDR_ALARM);

  // locked time writes are dropped whole, pointer included
  wire tWrHi = wrTime && wStrbQ[1] && valueWriteUnlock;
  wire tWrLo = wrTime && wStrbQ[0] && valueWriteUnlock;
  wire aWrHi = wrAlarm && wStrbQ[1];
  wire aWrLo = wrAlarm && wStrbQ[0];

  // timebase: trim applies to the first second of each minute
  wire        oscTick    = xtalClk && !oscPrev;
  wire [17:0] trimPulses = {{8{driftTrim[7]}}, driftTrim, 2'b00};
  wire [17:0] secTarget  = (sec == `CCVW_ZERO) ? (`CCVW_SEC_END - trimPulses)
                                               : `CCVW_SEC_END;
  wire        secEnd     = calendarEnable && oscTick && (preCnt >= secTarget);
  wire        halfSecond = (preCnt >= `CCVW_HALF_START);
  wire        ripple     = calendarEnable &&
                           ((preCnt + `CCVW_RIPPLE_TICKS) >= secTarget);

  // carry conditions of the calendar cascade
  wire secLast = (sec == `CCVW_SEC_LAST);
  wire minLast = (min == `CCVW_SEC_LAST);
  wire hrLast  = (hr == `CCVW_HR_LAST);
  wire dayLast = (day == lastDay(mon, yr));
  wire monLast = (mon == `CCVW_MON_LAST);

  // axi write channels: address and data taken in either order
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld  <= 1'b0;
      awAddrQ <= 8'h00;
      wHeld   <= 1'b0;
      wDataQ  <= 32'h00000000;
      wStrbQ  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `CCVW_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        awHeld  <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld  <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (wrDo) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= isMapped(awAddrQ) ? `CCVW_RESP_OK : `CCVW_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read data mux, sampled at the address handshake
  always @* begin
    rdMux = 32'h00000000;
    if (araddr == `CCVW_ADDR_CFG) begin
      rdMux[15:0] = {calendarEnable, 1'b0, valueWriteUnlock, ripple, halfSecond,
                     pinOutputEnable, valuePtr, driftTrim};
    end else if (araddr == `CCVW_ADDR_TIME) begin
      case (valuePtr)
        `CCVW_PTR_MINUTES_SECONDS_PAIR: rdMux[15:0] = {min, sec};
        `CCVW_PTR_WDHR:   rdMux[15:0] = {wday, hr};
        `CCVW_PTR_MONDAY: rdMux[15:0] = {mon, day};
        default:          rdMux[15:0] = {`CCVW_ZERO, yr};
      endcase
    end else if (araddr == `CCVW_ADDR_ALARM) begin
      case (alarmPtr)
        `CCVW_PTR_MINUTES_SECONDS_PAIR: rdMux[15:0] = {alarmMin, alarmSec};
        `CCVW_PTR_WDHR:   rdMux[15:0] = {alarmWday, alarmHr};
        `CCVW_PTR_MONDAY: rdMux[15:0] = {alarmMon, alarmDay};
        default:          rdMux[15:0] = 16'h0000;
      endcase
    end else if (araddr == `CCVW_ADDR_ALCFG) begin
      rdMux[15:0] = {alarmCfgTop, alarmPtr, alarmRepeat};
    end else if (araddr == `CCVW_ADDR_PINSEL) begin
      rdMux[0] = secondsClockSel;
    end
  end

  // axi read channel; data latched before the pointer steps down
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `CCVW_RESP_OK;
    end else if (rdDo) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= isMapped(araddr) ? `CCVW_RESP_OK : `CCVW_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // unlock key: 55h then aah opens a short window for the unlock bit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyStage <= 1'b0;
      armCnt   <= 8'h00;
    end else if (wrKey) begin
      if (wDataQ[`CCVW_BYTE_LO] == `CCVW_KEY_FIRST) begin
        keyStage <= 1'b1;
        armCnt   <= 8'h00;
      end else if (keyStage && wDataQ[`CCVW_BYTE_LO] == `CCVW_KEY_SECOND) begin
        keyStage <= 1'b0;
        armCnt   <= UNLOCK_CYC;
      end else begin
        keyStage <= 1'b0;
        armCnt   <= 8'h00;
      end
    end else if (armCnt != 8'h00) begin
      armCnt <= armCnt - 8'h01;
    end
  end

  // config_trim_register survives every reset but power-on
  always @(posedge ref_clk or negedge porRst_n) begin
    if (!porRst_n) begin
      calendarEnable   <= 1'b0;
      valueWriteUnlock <= 1'b0;
      pinOutputEnable  <= 1'b0;
      valuePtr         <= `CCVW_PTR_MINUTES_SECONDS_PAIR;
      driftTrim        <= 8'h00;
    end else begin
      if (wrCfg && wStrbQ[1]) begin
        if (valueWriteUnlock) begin
          calendarEnable <= wDataQ[`CCVW_CFG_EN];
        end
        // clearing always works; setting only inside the key window
        valueWriteUnlock <= wDataQ[`CCVW_CFG_UNLOCK] &&
                            (valueWriteUnlock || armCnt != 8'h00);
        pinOutputEnable  <= wDataQ[`CCVW_CFG_OE];
        valuePtr         <= wDataQ[`CCVW_PTR_HI:`CCVW_PTR_LO];
      end else begin
        valuePtr <= ptrDec(valuePtr, {1'b0, tWrHi} + {1'b0, rdTime});
      end
      if (wrCfg && wStrbQ[0]) begin
        driftTrim <= wDataQ[`CCVW_BYTE_LO];
      end
    end
  end

  // alarm config, alarm window and pin select
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmCfgTop     <= 6'h00;
      alarmPtr        <= `CCVW_PTR_MINUTES_SECONDS_PAIR;
      alarmRepeat     <= 8'h00;
      alarmMin        <= 8'h00;
      alarmSec        <= 8'h00;
      alarmWday       <= 8'h00;
      alarmHr         <= 8'h00;
      alarmMon        <= 8'h00;
      alarmDay        <= 8'h00;
      secondsClockSel <= 1'b0;
    end else begin
      if (wrAlcfg && wStrbQ[1]) begin
        alarmCfgTop <= wDataQ[`CCVW_ALCFG_TOP];
        alarmPtr    <= wDataQ[`CCVW_PTR_HI:`CCVW_PTR_LO];
      end else begin
        alarmPtr <= ptrDec(alarmPtr, {1'b0, aWrHi} + {1'b0, rdAlarm});
      end
      if (wrAlcfg && wStrbQ[0]) begin
        alarmRepeat <= wDataQ[`CCVW_BYTE_LO];
      end
      if (aWrHi) begin
        case (alarmPtr)
          `CCVW_PTR_MINUTES_SECONDS_PAIR: alarmMin  <= wDataQ[`CCVW_BYTE_HI] & `CCVW_MASK_MINUTES_SECONDS_PAIR;
          `CCVW_PTR_WDHR:   alarmWday <= wDataQ[`CCVW_BYTE_HI] & `CCVW_MASK_WDAY;
          `CCVW_PTR_MONDAY: alarmMon  <= wDataQ[`CCVW_BYTE_HI] & `CCVW_MASK_MON;
          default:          alarmMin  <= alarmMin;
        endcase
      end
      if (aWrLo) begin
        case (alarmPtr)
          `CCVW_PTR_MINUTES_SECONDS_PAIR: alarmSec <= wDataQ[`CCVW_BYTE_LO] & `CCVW_MASK_MINUTES_SECONDS_PAIR;
          `CCVW_PTR_WDHR:   alarmHr  <= wDataQ[`CCVW_BYTE_LO] & `CCVW_MASK_HR;
          `CCVW_PTR_MONDAY: alarmDay <= wDataQ[`CCVW_BYTE_LO] & `CCVW_MASK_HR;
          default:          alarmSec <= alarmSec;
        endcase
      end
      if (wrPin) begin
        secondsClockSel <= wDataQ[0];
      end
    end
  end

  // prescaler; a write to the seconds byte restarts the second
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev <= 1'b0;
      preCnt  <= 18'd0;
    end else begin
      oscPrev <= xtalClk;
      if (tWrLo && valuePtr == `CCVW_PTR_MINUTES_SECONDS_PAIR) begin
        preCnt <= 18'd0;
      end else if (secEnd) begin
        preCnt <= 18'd0;
      end else if (calendarEnable && oscTick) begin
        preCnt <= preCnt + 18'd1;
      end
    end
  end

  // calendar fields; a software write in the same cycle beats the tick
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec  <= `CCVW_ZERO;
      min  <= `CCVW_ZERO;
      hr   <= `CCVW_ZERO;
      wday <= `CCVW_ZERO;
      day  <= `CCVW_FIRST_ONE;
      mon  <= `CCVW_FIRST_ONE;
      yr   <= `CCVW_ZERO;
    end else if (tWrHi || tWrLo) begin
      case (valuePtr)
        `CCVW_PTR_MINUTES_SECONDS_PAIR: begin
          if (tWrHi) min <= wDataQ[`CCVW_BYTE_HI] & `CCVW_MASK_MINUTES_SECONDS_PAIR;
          if (tWrLo) sec <= wDataQ[`CCVW_BYTE_LO] & `CCVW_MASK_MINUTES_SECONDS_PAIR;
        end
        `CCVW_PTR_WDHR: begin
          if (tWrHi) wday <= wDataQ[`CCVW_BYTE_HI] & `CCVW_MASK_WDAY;
          if (tWrLo) hr   <= wDataQ[`CCVW_BYTE_LO] & `CCVW_MASK_HR;
        end
        `CCVW_PTR_MONDAY: begin
          if (tWrHi) mon <= wDataQ[`CCVW_BYTE_HI] & `CCVW_MASK_MON;
          if (tWrLo) day <= wDataQ[`CCVW_BYTE_LO] & `CCVW_MASK_HR;
        end
        default: begin
          if (tWrLo) yr <= wDataQ[`CCVW_BYTE_LO];
        end
      endcase
    end else if (secEnd) begin
      sec <= secLast ? `CCVW_ZERO : bcdInc(sec);
      if (secLast) begin
        min <= minLast ? `CCVW_ZERO : bcdInc(min);
        if (minLast) begin
          hr <= hrLast ? `CCVW_ZERO : bcdInc(hr);
          if (hrLast) begin
            wday <= (wday == `CCVW_WDAY_LAST) ? `CCVW_ZERO : bcdInc(wday);
            day  <= dayLast ? `CCVW_FIRST_ONE : bcdInc(day);
            if (dayLast) begin
              mon <= monLast ? `CCVW_FIRST_ONE : bcdInc(mon);
              if (monLast) begin
                yr <= (yr == `CCVW_YR_LAST) ? `CCVW_ZERO : bcdInc(yr);
              end
            end
          end
        end
      end
    end
  end

  // pin output; seconds clock is high in the first half of each second
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      calPin   <= 1'b0;
      calPinOe <= 1'b0;
    end else begin
      calPin   <= pinOutputEnable &&
                  (secondsClockSel ? !halfSecond : alarmPulse);
      calPinOe <= pinOutputEnable;
    end
  end

endmodule

// ===== testbench/ccvw_calendar_clock_assertions.sv
`timescale 1ns/1ps
`include "ccvw_calendar_clock_map.vh"

module ccvw_calendar_clock_assertions (
  // clock and resets
  input wire        ref_clk,
  input wire        rst_n,
  input wire        porRst_n,
  // write channels
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  // read channels
  input wire [7:0]  araddr,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  input wire        rvalid,
  input wire        rready,
  // pin
  input wire        calPin,
  input wire        calPinOe
);
  // one domain; either reset quiets every check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !porRst_n);

  // both halves of a write taken while no response is pending
  sequence wrTaken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence

  // read request taken at a given address
  sequence rdAt(logic [7:0] a);
    arvalid && arready && araddr == a;
  endsequence

  a_pin_off_disabled: assert property (!calPinOe |-> !calPin)
    else $error("pin high while output disabled");
  a_write_answer: assert property (wrTaken |-> ##[1:2] bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before handshake");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before handshake");
  a_arready_tie: assert property (arready == !rvalid)
    else $error("read address ready wrong");
  a_cfg_unused_zero: assert property (rdAt(`CCVW_ADDR_CFG) |=> rdata[31:16] == 16'h0 && !rdata[14])
    else $error("unused config bits read nonzero");
  a_ripple_needs_en: assert property (rdAt(`CCVW_ADDR_CFG) |=> !rdata[12] || rdata[15])
    else $error("ripple flag while calendar off");
  a_key_reads_zero: assert property (rdAt(`CCVW_ADDR_KEY) |=> rdata == 32'h0)
    else $error("key register readable");
  a_unmapped_err: assert property (arvalid && arready && araddr > 8'h14
      |=> rresp == `CCVW_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_time_digits: assert property (rdAt(`CCVW_ADDR_TIME)
      |=> rdata[3:0] <= 4'h9 && rdata[11:8] <= 4'h9)
    else $error("time window digit not decimal");
endmodule

bind ccvw_calendar_clock ccvw_calendar_clock_assertions chk (.*);

// ===== testbench/ccvw_calendar_clock_tb.sv
`timescale 1ns/1ps
`include "ccvw_calendar_clock_map.vh"

module ccvw_calendar_clock_tb;
  logic        ref_clk, rst_n, porRst_n, xtalClk, alarmPulse;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdVal;
  logic [3:0]  wstrb;
  logic [1:0]  lastResp;
  wire         awready, wready, bvalid, arready, rvalid, calPin, calPinOe;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          fails, compares, i;
  logic [15:0] walk [4];
  logic [15:0] alrm [5];
  localparam logic [31:0] M = 32'hffffe7ff; // hides the time-varying flags

  ccvw_calendar_clock dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .porRst_n(porRst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .xtalClk(xtalClk), .alarmPulse(alarmPulse),
    .calPin(calPin), .calPinOe(calPinOe)
  );

  // 50 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // fastest oscillator the sampler can see: one tick every two cycles;
  // starts itself from unknown so this process is its only driver
  always @(posedge ref_clk) xtalClk <= (xtalClk !== 1'b1);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // axi4-lite write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 100);
    if (n >= 100) fails++;
    lastResp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 100);
    if (n >= 100) fails++;
    rdVal = rdata;
    lastResp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(rdVal & m, e);
  endtask

  // key sequence, optional stall, then the unlock bit with enable
  task automatic unlock(input int gap);
    wr(`CCVW_ADDR_KEY, 32'h55, 4'h1);
    wr(`CCVW_ADDR_KEY, 32'haa, 4'h1);
    repeat (gap) @(posedge ref_clk);
    wr(`CCVW_ADDR_CFG, 32'ha000, 4'h2);
  endtask

  // hang guard, well past the expected run of about 66200 cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails++;
    end_of_test;
  end

  initial begin
    {rst_n, porRst_n, alarmPulse} = 3'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    walk = '{16'h0024, 16'h0228, 16'h0323, 16'h5958};
    alrm = '{16'h0000, 16'h0115, 16'h0207, 16'h3045, 16'h3045};
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    porRst_n <= 1'b1;
    rdChk(`CCVW_ADDR_CFG, M, 32'h0);
    wr(`CCVW_ADDR_CFG, 32'h5a, 4'h1);
    // plain reset in mid-run must keep the trim
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdChk(`CCVW_ADDR_CFG, M, 32'h5a);
    wr(`CCVW_ADDR_TIME, 32'h1234, 4'h3);
    rdChk(`CCVW_ADDR_TIME, '1, 32'h0);
    wr(`CCVW_ADDR_CFG, 32'ha000, 4'h2);
    rdChk(`CCVW_ADDR_CFG, M, 32'h5a);
    unlock(12);
    rdChk(`CCVW_ADDR_CFG, M, 32'h5a);
    unlock(0);
    wr(`CCVW_ADDR_CFG, 32'ha300, 4'h2);
    rdChk(`CCVW_ADDR_CFG, M, 32'ha35a);
    for (i = 0; i < 4; i++) wr(`CCVW_ADDR_TIME, {16'h0, walk[i]}, 4'h3);
    rdChk(`CCVW_ADDR_CFG, M, 32'ha05a);
    wr(`CCVW_ADDR_CFG, 32'ha300, 4'h2);
    for (i = 0; i < 5; i++) rdChk(`CCVW_ADDR_TIME, '1, {16'h0, walk[i > 3 ? 3 : i]});
    // alarm window: pointer 11 swallows the write, then walks down;
    // raw mask and repeat fields ride along untouched
    wr(`CCVW_ADDR_ALCFG, 32'h7f3c, 4'h3);
    wr(`CCVW_ADDR_ALARM, 32'h1111, 4'h3);
    for (i = 1; i < 4; i++) wr(`CCVW_ADDR_ALARM, {16'h0, alrm[i]}, 4'h3);
    rdChk(`CCVW_ADDR_ALCFG, '1, 32'h7c3c);
    wr(`CCVW_ADDR_ALCFG, 32'h0300, 4'h2);
    for (i = 0; i < 5; i++) rdChk(`CCVW_ADDR_ALARM, '1, {16'h0, alrm[i]});
    // pin: alarm pulse, then seconds clock early in the second
    wr(`CCVW_ADDR_PINSEL, 32'h0, 4'h1);
    wr(`CCVW_ADDR_CFG, 32'ha400, 4'h2);
    alarmPulse <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check({calPinOe, calPin}, 2'b11);
    alarmPulse <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check({calPinOe, calPin}, 2'b10);
    wr(`CCVW_ADDR_PINSEL, 32'h1, 4'h1);
    repeat (3) @(posedge ref_clk);
    check({calPinOe, calPin}, 2'b11);
    wr(`CCVW_ADDR_CFG, 32'ha000, 4'h2);
    repeat (3) @(posedge ref_clk);
    check({calPinOe, calPin}, 2'b00);
    // leap day rollover from the last second of feb 28th 2024
    wr(`CCVW_ADDR_TIME, 32'h5959, 4'h3);
    rdChk(`CCVW_ADDR_CFG, 32'h1800, 32'h0);
    repeat (40000) @(posedge ref_clk);
    rdChk(`CCVW_ADDR_CFG, 32'h1800, 32'h800);
    // sample lands about 30 ticks before the second rolls over
    repeat (25470) @(posedge ref_clk);
    rdChk(`CCVW_ADDR_CFG, 32'h1000, 32'h1000);
    repeat (527) @(posedge ref_clk);
    walk = '{16'h0024, 16'h0229, 16'h0400, 16'h0000};
    wr(`CCVW_ADDR_CFG, 32'ha300, 4'h2);
    for (i = 0; i < 4; i++) rdChk(`CCVW_ADDR_TIME, '1, {16'h0, walk[i]});
    // lock again and show the window refuses writes
    wr(`CCVW_ADDR_CFG, 32'h8000, 4'h2);
    rdChk(`CCVW_ADDR_CFG, M, 32'h805a);
    wr(`CCVW_ADDR_TIME, 32'h1111, 4'h3);
    rdChk(`CCVW_ADDR_TIME, 32'hff00, 32'h0);
    rdChk(`CCVW_ADDR_KEY, '1, 32'h0);
    rdChk(8'h18, '1, 32'h0);
    check(lastResp, `CCVW_RESP_SLVERR);
    wr(8'h18, 32'h1, 4'hf);
    check(lastResp, `CCVW_RESP_SLVERR);
    end_of_test;
  end
endmodule
